/* File: srblc_defines.vh */
// Constants of the synchronous rectifier blanking and light-load controller
`ifndef SRBLC_DEFINES_VH
`define SRBLC_DEFINES_VH
// Clock period in ns (100 MHz)
`define SRBLC_CLK_NS        10
// Light-load nominal times in us and derived cycle counts
`define SRBLC_LL_70_US      70
`define SRBLC_LL_130_US     130
`define SRBLC_LL_280_US     280
`define SRBLC_LL_540_US     540
`define SRBLC_LL_1075_US    1075
`define SRBLC_US_TO_CYC(u)  ((u) * 1000 / `SRBLC_CLK_NS)
// Light-load select codes
`define SRBLC_SEL_70        3'h0
`define SRBLC_SEL_130       3'h1
`define SRBLC_SEL_280       3'h2
`define SRBLC_SEL_540       3'h3
`define SRBLC_SEL_1075      3'h4
`define SRBLC_SEL_FORCE_DIS 3'h5
`define SRBLC_SEL_LL_OFF    3'h6
// Counter widths
`define SRBLC_TW            16
`define SRBLC_LW            18
`define SRBLC_MW            4
// Default blanking lengths in cycles and wake recovery time
`define SRBLC_MIN_ON_DEF    16'h0032
`define SRBLC_MIN_OFF_DEF   16'h0064
`define SRBLC_WAKE_REC_NS   1000
`define SRBLC_WAKE_REC_CYC  (`SRBLC_WAKE_REC_NS / `SRBLC_CLK_NS)
// Controller states
`define SRBLC_ST_START      3'h0
`define SRBLC_ST_OFFBLANK   3'h1
`define SRBLC_ST_ARMED      3'h2
`define SRBLC_ST_ON         3'h3
`define SRBLC_ST_REARM      3'h4
`define SRBLC_ST_WAITRST    3'h5
`define SRBLC_ST_WAKE       3'h6
`endif

/* File: srblc_ctrl.v */
// Synchronous rectifier blanking, exception timer and light-load control
`timescale 1ns/1ps
`default_nettype none
`include "srblc_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module srblc_ctrl
(
   // Clock and reset
   input  wire                   i_ref_clk,
   input  wire                   i_sys_rst,
   // Comparator outputs, high when sense is below / above the threshold
   input  wire                   i_below_turn_on_threshold,
   input  wire                   i_above_turn_off_threshold,
   input  wire                   i_above_blank_reset_threshold,
   input  wire                   i_sense_negative,
   input  wire                   i_steep_fall,
   // Configuration
   input  wire                   i_fast_slope_en,
   input  wire                   i_exception_en,
   input  wire [`SRBLC_MW-1:0]   i_exception_mult,
   input  wire [`SRBLC_TW-1:0]   i_min_on_cycles,
   input  wire [`SRBLC_TW-1:0]   i_min_off_cycles,
   input  wire [2:0]             i_light_load_select,
   // Outputs
   output reg                    o_gate_drive,
   output reg                    o_disable,
   output reg                    o_low_power
);
////////////////////////////////////////////////////////////////////////////////
localparam integer LL_70_I   = `SRBLC_US_TO_CYC(`SRBLC_LL_70_US);
localparam integer LL_130_I  = `SRBLC_US_TO_CYC(`SRBLC_LL_130_US);
localparam integer LL_280_I  = `SRBLC_US_TO_CYC(`SRBLC_LL_280_US);
localparam integer LL_540_I  = `SRBLC_US_TO_CYC(`SRBLC_LL_540_US);
localparam integer LL_1075_I = `SRBLC_US_TO_CYC(`SRBLC_LL_1075_US);
localparam integer WAKE_I    = `SRBLC_WAKE_REC_CYC;
// Counts are worked out as integers, then cut to the counter widths; all fit
localparam [`SRBLC_LW-1:0] LL_70    = LL_70_I[`SRBLC_LW-1:0];
localparam [`SRBLC_LW-1:0] LL_130   = LL_130_I[`SRBLC_LW-1:0];
localparam [`SRBLC_LW-1:0] LL_280   = LL_280_I[`SRBLC_LW-1:0];
localparam [`SRBLC_LW-1:0] LL_540   = LL_540_I[`SRBLC_LW-1:0];
localparam [`SRBLC_LW-1:0] LL_1075  = LL_1075_I[`SRBLC_LW-1:0];
localparam [`SRBLC_TW-1:0] WAKE_CYC = WAKE_I[`SRBLC_TW-1:0];
localparam [`SRBLC_TW-1:0] ONE_T    = 16'h0001;

// Two-flop synchronisers for all comparator inputs
reg  [4:0] sync1_q;
reg  [4:0] sync2_q;
reg        neg_prev_q;
always @(posedge i_ref_clk or posedge i_sys_rst)
begin
   if (i_sys_rst)
   begin
      sync1_q    <= 5'h00;
      sync2_q    <= 5'h00;
      neg_prev_q <= 1'b0;
   end
   else
   begin
      sync1_q    <= {i_steep_fall, i_sense_negative, i_above_blank_reset_threshold,
                     i_above_turn_off_threshold, i_below_turn_on_threshold};
      sync2_q    <= sync1_q;
      neg_prev_q <= sync2_q[3];
   end
end
wire on_cmp  = sync2_q[0];
wire off_cmp = sync2_q[1];
wire rst_cmp = sync2_q[2];
wire neg_s   = sync2_q[3];
wire steep_s = sync2_q[4];
wire neg_fall_edge = neg_s & ~neg_prev_q;
wire pos_edge      = ~neg_s & neg_prev_q;

// Fast slope wins if both options are asked
wire exc_active  = i_exception_en & ~i_fast_slope_en;
wire fast_active = i_fast_slope_en;

// Exception length is mult x min on time
wire [`SRBLC_TW+`SRBLC_MW-1:0] exc_len = i_min_on_cycles * i_exception_mult;

////////////////////////////////////////////////////////////////////////////////
// Light-load nominal length selection
reg  [`SRBLC_LW-1:0] ll_nom;
always @*
begin
   case (i_light_load_select)
      `SRBLC_SEL_70:   ll_nom = LL_70;
      `SRBLC_SEL_130:  ll_nom = LL_130;
      `SRBLC_SEL_280:  ll_nom = LL_280;
      `SRBLC_SEL_540:  ll_nom = LL_540;
      default:         ll_nom = LL_1075;
   endcase
end
wire ll_off   = (i_light_load_select == `SRBLC_SEL_LL_OFF);
wire ll_force = (i_light_load_select == `SRBLC_SEL_FORCE_DIS);

////////////////////////////////////////////////////////////////////////////////
// State machine and timers
reg  [2:0]                      st_q;
reg  [`SRBLC_TW-1:0]            blank_q;
reg  [`SRBLC_TW+`SRBLC_MW-1:0]  exc_q;
reg                             exc_run_q;
reg  [`SRBLC_LW-1:0]            ll_q;
reg                             ll_half_q;
reg                             ll_run_q;
wire [`SRBLC_LW-1:0] ll_limit = ll_half_q ? {1'b0, ll_nom[`SRBLC_LW-1:1]} : ll_nom;
wire ll_expire = ll_run_q & ~ll_off & (ll_q >= ll_limit);

always @(posedge i_ref_clk or posedge i_sys_rst)
begin
   if (i_sys_rst)
   begin
      st_q         <= `SRBLC_ST_START;
      blank_q      <= 16'h0000;
      exc_q        <= 20'h00000;
      exc_run_q    <= 1'b0;
      ll_q         <= 18'h00000;
      ll_half_q    <= 1'b0;
      ll_run_q     <= 1'b0;
      o_gate_drive <= 1'b0;
      o_disable    <= 1'b0;
      o_low_power  <= 1'b0;
   end
   else
   begin
      // Exception timer counts down while running
      if (exc_q != 20'h00000)
         exc_q <= exc_q - 20'h00001;
      else
         exc_run_q <= 1'b0;
      // Light-load timer
      if (ll_off)
      begin
         ll_run_q  <= 1'b0;
         ll_q      <= 18'h00000;
         ll_half_q <= 1'b0;
      end
      else if (neg_fall_edge)
      begin
         // Conduction starts: judge spacing against nominal
         if (ll_run_q && ll_q >= {2'b00, ll_nom[`SRBLC_LW-1:2]}
             && ll_q < {1'b0, ll_nom[`SRBLC_LW-1:1]})
            ll_half_q <= 1'b0;
         ll_q     <= 18'h00000;
         ll_run_q <= 1'b0;
      end
      else if (pos_edge)
      begin
         ll_q     <= 18'h00000;
         ll_run_q <= 1'b1;
      end
      else if (ll_expire)
      begin
         ll_q      <= 18'h00000;
         ll_half_q <= 1'b1;
         ll_run_q  <= 1'b0;
         o_disable <= 1'b1;
      end
      else if (ll_run_q && !neg_s)
         ll_q <= ll_q + 18'h00001;
      if (ll_force)
         o_disable <= 1'b1;
      // Disable forces the driver off and parks the sequencer
      if ((ll_expire && !neg_fall_edge) || ll_force || (o_disable && !neg_fall_edge))
      begin
         o_gate_drive <= 1'b0;
         o_low_power  <= 1'b1;
         st_q         <= `SRBLC_ST_START;
      end
      else if (o_disable && neg_fall_edge && !ll_force)
      begin
         // Wake on conduction start
         o_disable   <= 1'b0;
         o_low_power <= 1'b0;
         blank_q     <= WAKE_CYC;
         st_q        <= `SRBLC_ST_WAKE;
      end
      else
      begin
         case (st_q)
            `SRBLC_ST_START:
            begin
               o_gate_drive <= 1'b0;
               blank_q      <= i_min_off_cycles;
               if (rst_cmp)
                  st_q <= `SRBLC_ST_OFFBLANK;
            end
            `SRBLC_ST_WAKE:
            begin
               if (blank_q > ONE_T)
                  blank_q <= blank_q - ONE_T;
               else
                  st_q <= `SRBLC_ST_START;
            end
            `SRBLC_ST_OFFBLANK:
            begin
               // Dips restart the blank so ringing cannot arm, except a steep fall with fast slope on
               if (fast_active && steep_s)
                  st_q <= `SRBLC_ST_ARMED;
               else if (!rst_cmp)
                  blank_q <= i_min_off_cycles;
               else if (blank_q > ONE_T)
                  blank_q <= blank_q - ONE_T;
               else
                  st_q <= `SRBLC_ST_ARMED;
            end
            `SRBLC_ST_ARMED:
            begin
               if (on_cmp)
               begin
                  o_gate_drive <= 1'b1;
                  exc_q        <= exc_active ? exc_len : 20'h00000;
                  exc_run_q    <= exc_active;
                  blank_q      <= i_min_on_cycles;
                  st_q         <= `SRBLC_ST_ON;
               end
            end
            `SRBLC_ST_ON:
            begin
               if (blank_q > ONE_T)
                  blank_q <= blank_q - ONE_T;
               else if (off_cmp)
               begin
                  o_gate_drive <= 1'b0;
                  blank_q      <= i_min_on_cycles;
                  if (exc_run_q && exc_q != 20'h00000)
                     st_q <= `SRBLC_ST_REARM;
                  else
                     st_q <= `SRBLC_ST_WAITRST;
               end
            end
            `SRBLC_ST_REARM:
            begin
               // Turn-on comparator masked here until the min on blank runs out, to avoid chatter
               if (blank_q > ONE_T)
                  blank_q <= blank_q - ONE_T;
               else if (on_cmp && exc_q != 20'h00000)
               begin
                  o_gate_drive <= 1'b1;
                  blank_q      <= i_min_on_cycles;
                  st_q         <= `SRBLC_ST_ON;
               end
               else
                  st_q <= `SRBLC_ST_WAITRST;
            end
            `SRBLC_ST_WAITRST:
            begin
               blank_q <= i_min_off_cycles;
               if (rst_cmp)
                  st_q <= `SRBLC_ST_OFFBLANK;
            end
            default:
               st_q <= `SRBLC_ST_START;
         endcase
      end
   end
end
endmodule // srblc_ctrl
`default_nettype wire

/* File: srblc_sense_model.sv */
// Current-sense comparator model for the rectifier controller bench
`timescale 1ns/1ps
`default_nettype none
module srblc_sense_model
(
   // Sense level: 0 well positive, 1 conducting, 2 just above zero
   input  wire logic [1:0] i_level,
   // Comparator outputs
   output logic            o_below_on,
   output logic            o_above_off,
   output logic            o_above_rst,
   output logic            o_negative
);
   // One level feeds all four so the comparators never disagree
   always_comb
   begin
      o_below_on  = (i_level == 2'h1);
      o_above_off = (i_level != 2'h1);
      o_above_rst = (i_level == 2'h0);
      o_negative  = (i_level == 2'h1);
   end
endmodule // srblc_sense_model
`default_nettype wire

/* File: srblc_ctrl_props.sv */
// Concurrent checks on the ports of the rectifier controller
`timescale 1ns/1ps
`default_nettype none
`include "srblc_defines.vh"
module srblc_ctrl_props
(
   // Clock, reset and watched ports
   input wire logic                 i_ref_clk,
   input wire logic                 i_sys_rst,
   input wire logic                 i_below_turn_on_threshold,
   input wire logic                 i_sense_negative,
   input wire logic [`SRBLC_TW-1:0] i_min_on_cycles,
   input wire logic [2:0]           i_light_load_select,
   input wire logic                 o_gate_drive,
   input wire logic                 o_disable,
   input wire logic                 o_low_power
);
   logic [`SRBLC_TW-1:0] on_cnt_q;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         on_cnt_q <= '0;
      else
         on_cnt_q <= o_gate_drive ? on_cnt_q + 1'b1 : '0;
   end
   sequence s_gate_soon; ##[0:100] o_gate_drive; endsequence
   sequence s_forced; (i_light_load_select == `SRBLC_SEL_FORCE_DIS)[*8]; endsequence
   property p_lp_follow; $rose(o_disable) |=> o_low_power; endproperty
   property p_dis_gate; (o_disable || o_low_power) |-> !o_gate_drive; endproperty
   property p_ll_run; $rose(o_disable) |-> !$past(i_sense_negative, 3); endproperty
   property p_on_cause; $rose(o_gate_drive) |-> $past(i_below_turn_on_threshold, 2)
      || $past(i_below_turn_on_threshold, 3) || $past(i_below_turn_on_threshold, 4); endproperty
   property p_min_on; $fell(o_gate_drive) |-> on_cnt_q >= i_min_on_cycles; endproperty
   property p_wake; $fell(o_disable) |-> not s_gate_soon; endproperty
   property p_wake_lp; $fell(o_disable) |-> ##[0:1] !o_low_power; endproperty
   property p_force; s_forced |-> o_disable; endproperty
   property p_ll_off; (i_light_load_select == `SRBLC_SEL_LL_OFF)
      && ($past(i_light_load_select) == `SRBLC_SEL_LL_OFF) |-> !$rose(o_disable); endproperty
   a_lp_follow: assert property (p_lp_follow) else $error("low power missed");
   a_dis_gate: assert property (p_dis_gate) else $error("gate while off");
   a_ll_run: assert property (p_ll_run) else $error("idle timer early");
   a_on_cause: assert property (p_on_cause) else $error("gate without cause");
   a_min_on: assert property (p_min_on) else $error("on time short");
   a_wake: assert property (p_wake) else $error("gate too soon");
   a_wake_lp: assert property (p_wake_lp) else $error("low power stuck");
   a_force: assert property (p_force) else $error("forced off missed");
   a_ll_off: assert property (p_ll_off) else $error("idle off ignored");
endmodule // srblc_ctrl_props
bind srblc_ctrl srblc_ctrl_props i_props
(
   .i_ref_clk                 (i_ref_clk),
   .i_sys_rst                 (i_sys_rst),
   .i_below_turn_on_threshold (i_below_turn_on_threshold),
   .i_sense_negative          (i_sense_negative),
   .i_min_on_cycles           (i_min_on_cycles),
   .i_light_load_select       (i_light_load_select),
   .o_gate_drive              (o_gate_drive),
   .o_disable                 (o_disable),
   .o_low_power               (o_low_power)
);
`default_nettype wire

/* File: sr_blanking_light_load_control_tb.sv */
// Self-checking bench of the rectifier blanking and light-load controller
`timescale 1ns/1ps
`default_nettype none
`include "srblc_defines.vh"
module sr_blanking_light_load_control_tb;
   logic       clk, rst, steep, fast, exc;
   logic [1:0] lvl;
   logic [3:0] mult;
   logic [2:0] sel;
   wire logic  below_on, above_off, above_rst, negative, gate, dis, lp;
   int         mismatches, compares;
   // Rows: select, idle wait, expected, extra wait, expected; flyback picks long
   int         rows [7][5] = '{'{0, 6970, 0, 60, 1}, '{1, 12970, 0, 60, 1},
      '{2, 27970, 0, 60, 1}, '{3, 5000, 0, 10, 0}, '{4, 5000, 0, 10, 0},
      '{5, 20, 1, 10, 1}, '{6, 10000, 0, 10, 0}};
   srblc_sense_model i_sense (.i_level(lvl), .o_below_on(below_on), .o_above_off(above_off),
      .o_above_rst(above_rst), .o_negative(negative));
   srblc_ctrl i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_below_turn_on_threshold(below_on),
      .i_above_turn_off_threshold(above_off), .i_above_blank_reset_threshold(above_rst),
      .i_sense_negative(negative), .i_steep_fall(steep), .i_fast_slope_en(fast),
      .i_exception_en(exc), .i_exception_mult(mult), .i_min_on_cycles(`SRBLC_MIN_ON_DEF),
      .i_min_off_cycles(`SRBLC_MIN_OFF_DEF), .i_light_load_select(sel),
      .o_gate_drive(gate), .o_disable(dis), .o_low_power(lp));
   task chk(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %b seen %b", name, exp, got);
      end
   endtask
   task step(input logic [1:0] l, input int n);
      lvl <= l;
      repeat (n) @(posedge clk);
   endtask
   task do_reset;
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   task end_sim;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run is near 91k cycles
   initial
   begin
      #980000;
      mismatches++;
      end_sim();
   end
   initial
   begin
      {steep, fast, exc, lvl} = '0;
      mult = 4'h4; // Exception 200 cycles stays under a third of the period
      for (int r = 0; r < 7; r++)
      begin
         sel <= 3'(rows[r][0]);
         do_reset();
         step(2'h1, 20);
         step(2'h0, rows[r][1]);
         chk("disable", 1'(rows[r][2]), dis);
         step(2'h0, rows[r][3]);
         chk("disable", 1'(rows[r][4]), dis);
      end
      sel <= `SRBLC_SEL_LL_OFF;
      rst <= 1'b1;
      @(posedge clk);
      chk("gate", 1'b0, gate);
      chk("disable", 1'b0, dis);
      do_reset();
      step(2'h0, 150);
      step(2'h1, 6);
      chk("gate", 1'b1, gate);
      step(2'h2, 30);
      chk("gate", 1'b1, gate);
      step(2'h2, 30);
      chk("gate", 1'b0, gate);
      step(2'h0, 50);
      step(2'h2, 5);
      step(2'h0, 70);
      step(2'h1, 6);
      chk("gate", 1'b0, gate);
      step(2'h0, 120);
      step(2'h1, 6);
      chk("gate", 1'b1, gate);
      step(2'h2, 80);
      {fast, exc} <= 2'b11;
      step(2'h0, 10);
      steep <= 1'b1;
      step(2'h1, 6);
      chk("gate", 1'b1, gate);
      steep <= 1'b0;
      step(2'h2, 60);
      step(2'h1, 60);
      chk("gate", 1'b0, gate);
      fast <= 1'b0;
      step(2'h0, 150);
      step(2'h1, 6);
      step(2'h2, 60);
      chk("gate", 1'b0, gate);
      step(2'h1, 30);
      chk("gate", 1'b0, gate);
      step(2'h1, 30);
      chk("gate", 1'b1, gate);
      step(2'h1, 120);
      step(2'h2, 60);
      step(2'h1, 60);
      chk("gate", 1'b0, gate);
      {exc, sel} <= {1'b0, `SRBLC_SEL_70};
      do_reset();
      step(2'h1, 20);
      step(2'h0, 7030);
      chk("low power", 1'b1, lp);
      step(2'h1, 20);
      chk("disable", 1'b0, dis);
      step(2'h0, 3400);
      chk("disable", 1'b0, dis);
      step(2'h0, 130);
      chk("disable", 1'b1, dis);
      step(2'h1, 20);
      step(2'h0, 1000);
      step(2'h1, 20);
      step(2'h0, 3530);
      chk("disable", 1'b1, dis);
      step(2'h1, 20);
      step(2'h0, 2500);
      step(2'h1, 20);
      step(2'h0, 4000);
      chk("disable", 1'b0, dis);
      end_sim();
   end
endmodule // sr_blanking_light_load_control_tb
`default_nettype wire
